/* File: include/chkc_pkg.sv */
// ****************************************************************
// Charger and key configuration package
// ****************************************************************
package chkc_pkg;

   // Register count and first address of the bank
   localparam int NUM_REGS = 11;
   localparam logic [7:0] BASE_ADDR = 8'h33;

   // Register addresses
   localparam logic [7:0] ADDR_CHARGE_CONTROL_PRIMARY = 8'h33;
   localparam logic [7:0] ADDR_CHARGE_CONTROL_TIMEOUTS = 8'h34;
   localparam logic [7:0] ADDR_BACKUP_CELL_CHARGE_CONTROL = 8'h35;
   localparam logic [7:0] ADDR_POWER_KEY_TIMING = 8'h36;
   localparam logic [7:0] ADDR_CONVERTER_FREQUENCY_TRIM = 8'h37;
   localparam logic [7:0] ADDR_CHARGE_COLD_THRESHOLD = 8'h38;
   localparam logic [7:0] ADDR_CHARGE_HOT_THRESHOLD = 8'h39;
   localparam logic [7:0] ADDR_SUPPLY_WARNING_FIRST = 8'h3A;
   localparam logic [7:0] ADDR_SUPPLY_WARNING_SECOND = 8'h3B;
   localparam logic [7:0] ADDR_DISCHARGE_COLD_THRESHOLD = 8'h3C;
   localparam logic [7:0] ADDR_DISCHARGE_HOT_THRESHOLD = 8'h3D;

   // Register indexes within the bank
   localparam logic [3:0] IDX_PRIMARY = 4'h0;
   localparam logic [3:0] IDX_TIMEOUTS = 4'h1;
   localparam logic [3:0] IDX_BACKUP = 4'h2;
   localparam logic [3:0] IDX_KEY = 4'h3;
   localparam logic [3:0] IDX_FREQ = 4'h4;

   // Reset values, index 10 down to 0; primary low nibble is a parameter
   localparam logic [NUM_REGS-1:0][7:0] RST_VALS = {
      8'h16, 8'hFC, 8'h5F, 8'h68, 8'h1F, 8'hA5,
      8'h08, 8'h9D, 8'h22, 8'h45, 8'hC0};
   // Writable bits, index 10 down to 0; zero bits keep reset contents
   localparam logic [NUM_REGS-1:0][7:0] WR_MASKS = {
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'h0F, 8'hFF, 8'hE3, 8'hD3, 8'hFF};

   // Bits per serial byte
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Timing: one millisecond tick at the reference clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int MS_TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Key and power-good times in milliseconds
   localparam logic [13:0] STARTUP_MS_0 = 14'd128;
   localparam logic [13:0] STARTUP_MS_1 = 14'd3000;
   localparam logic [13:0] STARTUP_MS_2 = 14'd1000;
   localparam logic [13:0] STARTUP_MS_3 = 14'd2000;
   localparam logic [13:0] LONG_MS_0 = 14'd1000;
   localparam logic [13:0] LONG_MS_1 = 14'd1500;
   localparam logic [13:0] LONG_MS_2 = 14'd2000;
   localparam logic [13:0] LONG_MS_3 = 14'd2500;
   localparam logic [13:0] OFF_MS_0 = 14'd4000;
   localparam logic [13:0] OFF_MS_1 = 14'd6000;
   localparam logic [13:0] OFF_MS_2 = 14'd8000;
   localparam logic [13:0] OFF_MS_3 = 14'd10000;
   localparam logic [6:0] PGOOD_MS_SHORT = 7'd8;
   localparam logic [6:0] PGOOD_MS_LONG = 7'd64;

   // Field layouts
   typedef struct packed {
      logic enable;
      logic [1:0] target_v;
      logic end_15pct;
      logic [3:0] current;
   } chkc_primary_type;

   typedef struct packed {
      logic [1:0] pre_timeout;
      logic rsv_hi;
      logic led_flash;
      logic [1:0] rsv_lo;
      logic [1:0] cc_timeout;
   } chkc_timeouts_type;

   typedef struct packed {
      logic enable;
      logic [1:0] target_v;
      logic [2:0] rsv;
      logic [1:0] current;
   } chkc_backup_type;

   typedef struct packed {
      logic [1:0] startup;
      logic [1:0] long_press;
      logic auto_off;
      logic pgood_long;
      logic [1:0] off_time;
   } chkc_key_type;

   typedef struct packed {
      logic [3:0] rsv;
      logic [3:0] trim;
   } chkc_freq_type;

   // Decoded settings handed to the analog side
   typedef struct packed {
      chkc_primary_type primary;
      chkc_timeouts_type timeouts;
      chkc_backup_type backup;
      chkc_key_type key;
      chkc_freq_type freq;
      logic [7:0] charge_cold_limit;
      logic [7:0] charge_hot_limit;
      logic [7:0] supply_warn_first;
      logic [7:0] supply_warn_second;
      logic [7:0] discharge_cold_limit;
      logic [7:0] discharge_hot_limit;
   } chkc_config_type;

   // Serial slave states, Gray along the write path
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ACK_ADDR = 4'h3,
      ST_REG = 4'h2,
      ST_ACK_REG = 4'h6,
      ST_WRITE = 4'h7,
      ST_ACK_WR = 4'h5,
      ST_READ = 4'h4,
      ST_MACK = 4'hC
   } chkc_state_type;

endpackage

/* File: hdl/chkc_regs.sv */
`timescale 1ns/1ns
module chkc_regs
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
   parameter int TICK_CYCLES = chkc_pkg::MS_TICK_CYCLES,
   parameter logic [3:0] CHG_CUR_RESET = 4'h0
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic power_key_n,
   input wire logic power_startup,
   output logic power_good_output,
   output logic startup_press,
   output logic long_press,
   output logic shutdown_req,
   output chkc_pkg::chkc_config_type cfg_out
);
   import chkc_pkg::*;

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************
   logic [2:0] sync1_ff; // First stage, read only by second
   logic [2:0] sync2_ff; // Safe copies of scl, sda, key
   logic [2:0] hist_ff; // Previous safe copies
   logic scl, sda, key_down, scl_d, sda_d;
   logic scl_rise, scl_fall, start_seen, stop_seen;

   // Two-stage capture of the pins
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_ff <= 3'h7;
         sync2_ff <= 3'h7;
         hist_ff <= 3'h7;
      end
      else
      begin
         sync1_ff <= {scl_in, sda_in, power_key_n};
         sync2_ff <= sync1_ff;
         hist_ff <= sync2_ff;
      end
   end

   assign scl = sync2_ff[2];
   assign sda = sync2_ff[1];
   assign key_down = ~sync2_ff[0];
   assign scl_d = hist_ff[2];
   assign sda_d = hist_ff[1];
   assign scl_rise = scl & ~scl_d;
   assign scl_fall = ~scl & scl_d;
   // Data moving while the clock is high marks start or stop
   assign start_seen = scl & scl_d & sda_d & ~sda;
   assign stop_seen = scl & scl_d & ~sda_d & sda;

   // ****************************************************************
   // Serial slave state machine
   // ****************************************************************
   chkc_state_type state_ff; // Current slave state
   logic [3:0] bit_cnt_ff; // Bits taken or sent in this byte
   logic [7:0] shift_ff; // Received byte or byte being sent
   logic [7:0] ptr_ff; // Register pointer
   logic rw_ff; // Read request seen in address byte
   logic mack_ff; // Master acknowledged the last read byte
   logic drive_ff; // Pull sda low
   logic [NUM_REGS-1:0][7:0] regs_ff; // Register storage
   logic hit; // Pointer lies in the bank
   logic [3:0] idx; // Index of the pointed register
   logic [7:0] rd_data; // Read value at the pointer
   logic byte_done; // Eighth bit taken, clock now low
   logic wr_en; // Write strobe into the bank
   logic [7:0] ptr_diff; // Pointer less base

   assign ptr_diff = ptr_ff - BASE_ADDR;
   assign hit = (ptr_ff >= BASE_ADDR) && (ptr_diff < 8'(NUM_REGS));
   assign idx = ptr_diff[3:0];
   // Unmapped addresses read as zero
   assign rd_data = hit ? regs_ff[idx] : 8'h00;
   assign byte_done = scl_fall && (bit_cnt_ff == BYTE_BITS);
   assign wr_en = (state_ff == ST_WRITE) && byte_done && hit;

   // Byte framing and acknowledge sequencing
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         rw_ff <= 1'b0;
         mack_ff <= 1'b0;
         drive_ff <= 1'b0;
      end
      else if (stop_seen)
      begin
         // Stop ends any transfer
         state_ff <= ST_IDLE;
         drive_ff <= 1'b0;
      end
      else if (start_seen)
      begin
         // Start or repeated start opens an address byte
         state_ff <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
         drive_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            ST_ADDR, ST_REG, ST_WRITE:
            begin
               // Sample on rising clock, act once eight bits are in
               if (scl_rise)
               begin
                  shift_ff <= {shift_ff[6:0], sda};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               else if (byte_done)
               begin
                  bit_cnt_ff <= 4'h0;
                  if (state_ff == ST_ADDR)
                  begin
                     // Answer only our own address
                     if (shift_ff[7:1] == DEV_ADDR)
                     begin
                        rw_ff <= shift_ff[0];
                        drive_ff <= 1'b1;
                        state_ff <= ST_ACK_ADDR;
                     end
                     else
                        state_ff <= ST_IDLE;
                  end
                  else
                  begin
                     drive_ff <= 1'b1;
                     state_ff <= (state_ff == ST_REG) ? ST_ACK_REG
                                                      : ST_ACK_WR;
                  end
               end
            end
            ST_ACK_ADDR:
            begin
               // Release ack, then start sending or take register
               if (scl_fall)
               begin
                  if (rw_ff)
                  begin
                     shift_ff <= rd_data;
                     drive_ff <= ~rd_data[7];
                     state_ff <= ST_READ;
                  end
                  else
                  begin
                     drive_ff <= 1'b0;
                     state_ff <= ST_REG;
                  end
               end
            end
            ST_ACK_REG, ST_ACK_WR:
            begin
               // Further bytes are register data
               if (scl_fall)
               begin
                  drive_ff <= 1'b0;
                  state_ff <= ST_WRITE;
               end
            end
            ST_READ:
            begin
               // Shift out on each falling clock
               if (scl_fall)
               begin
                  if (bit_cnt_ff == BYTE_BITS - 4'h1)
                  begin
                     bit_cnt_ff <= 4'h0;
                     drive_ff <= 1'b0;
                     mack_ff <= 1'b0;
                     state_ff <= ST_MACK;
                  end
                  else
                  begin
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     drive_ff <= ~shift_ff[6];
                  end
               end
            end
            ST_MACK:
            begin
               // Low sda at rising clock asks for another byte
               if (scl_rise)
                  mack_ff <= ~sda;
               else if (scl_fall)
               begin
                  if (mack_ff)
                  begin
                     shift_ff <= rd_data;
                     drive_ff <= ~rd_data[7];
                     state_ff <= ST_READ;
                  end
                  else
                     state_ff <= ST_IDLE;
               end
            end
            ST_IDLE:
               drive_ff <= 1'b0;
            default:
            begin
               state_ff <= ST_IDLE;
               drive_ff <= 1'b0;
            end
         endcase
      end
   end

   // Pointer load and auto increment after each data byte
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         ptr_ff <= 8'h00;
      else if ((state_ff == ST_REG) && byte_done)
         ptr_ff <= shift_ff;
      else if ((state_ff == ST_WRITE) && byte_done)
         ptr_ff <= ptr_ff + 8'h01;
      else if ((state_ff == ST_READ) && scl_fall &&
               (bit_cnt_ff == BYTE_BITS - 4'h1))
         ptr_ff <= ptr_ff + 8'h01;
   end

   // Open-drain pin: value low, enable active low
   assign sda_out = 1'b0;
   assign sda_oe_n = ~drive_ff;

   // ****************************************************************
   // Register bank
   // ****************************************************************
   // Storage, writes merge through the writable mask
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         regs_ff <= RST_VALS;
         regs_ff[IDX_PRIMARY][3:0] <= CHG_CUR_RESET;
      end
      else if (wr_en)
         regs_ff[idx] <= (regs_ff[idx] & ~WR_MASKS[idx]) |
                         (shift_ff & WR_MASKS[idx]);
   end

   // Field decode towards the analog side
   assign cfg_out.primary = chkc_primary_type'(regs_ff[0]);
   assign cfg_out.timeouts = chkc_timeouts_type'(regs_ff[1]);
   assign cfg_out.backup = chkc_backup_type'(regs_ff[2]);
   assign cfg_out.key = chkc_key_type'(regs_ff[3]);
   assign cfg_out.freq = chkc_freq_type'(regs_ff[4]);
   assign cfg_out.charge_cold_limit = regs_ff[5];
   assign cfg_out.charge_hot_limit = regs_ff[6];
   assign cfg_out.supply_warn_first = regs_ff[7];
   assign cfg_out.supply_warn_second = regs_ff[8];
   assign cfg_out.discharge_cold_limit = regs_ff[9];
   assign cfg_out.discharge_hot_limit = regs_ff[10];

   // ****************************************************************
   // Power key and power-good timing
   // ****************************************************************
   logic [15:0] tick_cnt_ff; // Millisecond divider
   logic tick; // One-cycle millisecond enable
   logic [13:0] hold_ms_ff; // Milliseconds key held
   logic [13:0] nxt_hold_ms; // Held time after this tick
   logic [13:0] startup_ms, long_ms, off_ms; // Selected limits
   logic [6:0] pg_ms_ff; // Milliseconds since power startup
   logic [6:0] pg_limit; // Selected power-good delay
   logic off_cond; // Held beyond shutdown time, auto enabled
   chkc_key_type key_cfg;

   assign key_cfg = cfg_out.key;
   assign tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));
   assign nxt_hold_ms = (hold_ms_ff == 14'h3FFF) ? hold_ms_ff
                                                 : hold_ms_ff + 14'h1;

   // Limit selection from the key timing register
   always_comb
   begin
      case (key_cfg.startup)
         2'h0: startup_ms = STARTUP_MS_0;
         2'h1: startup_ms = STARTUP_MS_1;
         2'h2: startup_ms = STARTUP_MS_2;
         default: startup_ms = STARTUP_MS_3;
      endcase
      case (key_cfg.long_press)
         2'h0: long_ms = LONG_MS_0;
         2'h1: long_ms = LONG_MS_1;
         2'h2: long_ms = LONG_MS_2;
         default: long_ms = LONG_MS_3;
      endcase
      case (key_cfg.off_time)
         2'h0: off_ms = OFF_MS_0;
         2'h1: off_ms = OFF_MS_1;
         2'h2: off_ms = OFF_MS_2;
         default: off_ms = OFF_MS_3;
      endcase
   end

   assign pg_limit = key_cfg.pgood_long ? PGOOD_MS_LONG
                                        : PGOOD_MS_SHORT;
   assign off_cond = key_cfg.auto_off && key_down &&
                     (hold_ms_ff > off_ms);

   // Free-running millisecond divider
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         tick_cnt_ff <= 16'h0000;
      else if (tick)
         tick_cnt_ff <= 16'h0000;
      else
         tick_cnt_ff <= tick_cnt_ff + 16'h0001;
   end

   // Key hold counter and press events
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         hold_ms_ff <= 14'h0000;
         startup_press <= 1'b0;
         long_press <= 1'b0;
      end
      else
      begin
         startup_press <= 1'b0;
         long_press <= 1'b0;
         if (!key_down)
            hold_ms_ff <= 14'h0000;
         else if (tick)
         begin
            hold_ms_ff <= nxt_hold_ms;
            startup_press <= (nxt_hold_ms == startup_ms);
            long_press <= (nxt_hold_ms == long_ms);
         end
      end
   end

   // Shutdown request holds until reset
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         shutdown_req <= 1'b0;
      else if (off_cond)
         shutdown_req <= 1'b1;
   end

   // Power-good delay after power startup
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         pg_ms_ff <= 7'h00;
         power_good_output <= 1'b0;
      end
      else if (!power_startup)
      begin
         pg_ms_ff <= 7'h00;
         power_good_output <= 1'b0;
      end
      else if (pg_ms_ff >= pg_limit)
         power_good_output <= 1'b1;
      else if (tick)
         pg_ms_ff <= pg_ms_ff + 7'h01;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   logic past_reset_ff; // Reset seen last cycle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         past_reset_ff <= 1'b1;
      else
         past_reset_ff <= 1'b0;
   end

   a_reset_defaults: assert property (@(posedge ref_clk) disable iff (reset)
      past_reset_ff |-> (regs_ff[10:1] == RST_VALS[10:1]) &&
      (regs_ff[0][7:4] == RST_VALS[0][7:4]))
      else $error("register defaults wrong after reset");

   a_primary_write: assert property (@(posedge ref_clk) disable iff (reset)
      wr_en && (idx == IDX_PRIMARY) |=>
      (cfg_out.primary == chkc_primary_type'($past(shift_ff))))
      else $error("primary charge control not written");

   a_timeouts_rsv: assert property (@(posedge ref_clk) disable iff (reset)
      (regs_ff[1] & ~WR_MASKS[1]) == (RST_VALS[1] & ~WR_MASKS[1]))
      else $error("timeout register reserved bits changed");

   a_backup_rsv: assert property (@(posedge ref_clk) disable iff (reset)
      wr_en && (idx == IDX_BACKUP) |=>
      (regs_ff[2] == ((RST_VALS[2] & ~WR_MASKS[2]) |
                      ($past(shift_ff) & WR_MASKS[2]))))
      else $error("backup register write merged wrongly");

   a_freq_upper: assert property (@(posedge ref_clk) disable iff (reset)
      cfg_out.freq.rsv == RST_VALS[4][7:4])
      else $error("frequency reserved bits changed");

   a_idle_stable: assert property (@(posedge ref_clk) disable iff (reset)
      !wr_en |=> $stable(regs_ff))
      else $error("register changed without a write");

   a_shutdown_cause: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(shutdown_req) |-> $past(off_cond))
      else $error("shutdown without qualified key hold");

   a_pgood_delay: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(power_good_output) |-> $past(power_startup) &&
      ($past(pg_ms_ff) >= $past(pg_limit)))
      else $error("power good raised before its delay");

   a_pgood_drop: assert property (@(posedge ref_clk) disable iff (reset)
      !power_startup |=> !power_good_output ##1 !power_good_output)
      else $error("power good held without startup");

   c_reg_write: cover property (@(posedge ref_clk) disable iff (reset)
      wr_en);
   c_reg_read: cover property (@(posedge ref_clk) disable iff (reset)
      (state_ff == ST_MACK) && scl_fall && mack_ff);
   c_shutdown: cover property (@(posedge ref_clk) disable iff (reset)
      $rose(shutdown_req));
   c_pgood: cover property (@(posedge ref_clk) disable iff (reset)
      $rose(power_good_output));

endmodule

/* File: tb/chkc_master.sv */
`timescale 1ns/1ns
// ************************
// Serial bus master model
// ************************
module chkc_master
(
   input wire logic ref_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low,
   output logic got,
   output logic [7:0] rdata
);
   localparam int H = 6; // Half bit, above four clocks
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
      got = 1'b0;
      rdata = 8'h00;
   end
   // Wait on falling clock edges
   task automatic w(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // One bit; data moves only while clock low
   task automatic bx(input logic b, output logic r);
      sda_low = ~b;
      w(H);
      scl = 1'b1;
      w(H);
      r = sda;
      scl = 1'b0;
      w(1);
   endtask
   // Start when s is 1, stop when s is 0
   task automatic fr(input logic s);
      sda_low = ~s;
      w(H);
      scl = 1'b1;
      w(H);
      sda_low = s;
      w(H);
      if (s)
         scl = 1'b0;
      w(1);
   endtask
   // Byte plus ack bit; a read pulses got with the data
   task automatic xb(input logic [7:0] d, input logic ab, input logic rd);
      logic [7:0] r;
      logic a;
      for (int i = 7; i >= 0; i--)
         bx(d[i], r[i]);
      bx(ab, a);
      if (rd)
      begin
         rdata = r;
         got = 1'b1;
         w(1);
         got = 1'b0;
      end
   endtask
endmodule

/* File: tb/chkc_regs_tb_top.sv */
`timescale 1ns/1ns
// ************
// Bench top
// ************
module chkc_regs_tb_top;
   import chkc_pkg::*;
   logic ref_clk, reset, scl, m_low, sda, got, key_n, pst;
   logic sda_out, sda_oe_n, pg, sp, lp, sd;
   logic [7:0] rdata;
   chkc_config_type cfg;
   logic [7:0] q [$]; // Expected read data
   logic [7:0] ev [11]; // Expected contents
   logic [7:0] rv [11] = '{8'hC0, 8'h45, 8'h22, 8'h9D, 8'h08, 8'hA5,
      8'h1F, 8'h68, 8'h5F, 8'hFC, 8'h16};
   logic [7:0] wm [11] = '{8'hFF, 8'hD3, 8'hE3, 8'hFF, 8'h0F, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   int fail_count = 0, n_checks = 0, cyc = 0, sp_n = 0, lp_n = 0;
   assign sda = (m_low || !sda_oe_n) ? 1'b0 : 1'b1; // Pulled-up line
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   chkc_regs #(.TICK_CYCLES(4))
   dut_u (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_key_n(key_n),
      .power_startup(pst), .power_good_output(pg), .startup_press(sp),
      .long_press(lp), .shutdown_req(sd), .cfg_out(cfg));
   chkc_master m_u (.ref_clk(ref_clk), .sda(sda), .scl(scl),
      .sda_low(m_low), .got(got), .rdata(rdata));
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] s);
      n_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Start, device byte, register byte
   task automatic wa(input logic [7:0] dv, input logic [7:0] a);
      m_u.fr(1'b1);
      m_u.xb(dv, 1'b1, 1'b0);
      m_u.xb(a, 1'b1, 1'b0);
   endtask
   // Single read, expected value noted first
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      q.push_back(e);
      wa(8'h54, a);
      m_u.fr(1'b1);
      m_u.xb(8'h55, 1'b1, 1'b0);
      m_u.xb(8'hFF, 1'b1, 1'b1);
      m_u.fr(1'b0);
   endtask
   // Result watcher, pulse counters and hang limit
   always @(posedge ref_clk)
   begin
      cyc++;
      if (sp === 1'b1)
         sp_n++;
      if (lp === 1'b1)
         lp_n++;
      if (got)
         chk("read data", q.pop_front(), rdata);
      if (cyc == 60000)
      begin
         fail_count++;
         end_sim();
      end
   end
   initial
   begin
      logic [7:0] d;
      int pv;
      int tk [6] = '{126, 130, 998, 1002, 3998, 4003};
      logic [7:0] kx [6] = '{8'h00, 8'h20, 8'h20, 8'h24, 8'h24, 8'h25};
      key_n = 1'b1;
      pst = 1'b0;
      reset = 1'b1;
      void'($urandom(32'h6f89));
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      repeat (4) @(negedge ref_clk);
      for (int i = 0; i < 11; i++)
         rd(8'h33 + i[7:0], rv[i]);
      $display("test reset values done");
      wa(8'h54, 8'h33);
      for (int i = 0; i < 11; i++)
      begin
         d = 8'($urandom);
         m_u.xb(d, 1'b1, 1'b0);
         ev[i] = (d & wm[i]) | (rv[i] & ~wm[i]);
      end
      m_u.fr(1'b0);
      wa(8'h56, 8'h38);
      m_u.xb(~ev[5], 1'b1, 1'b0);
      m_u.fr(1'b0);
      for (int i = 0; i < 11; i++)
      begin
         rd(8'h33 + i[7:0], ev[i]);
         chk("config", ev[i], cfg[(10-i)*8 +: 8]);
      end
      rd(8'h3E, 8'h00);
      $display("test burst readback done");
      wa(8'h54, 8'h36);
      m_u.xb(8'h08, 1'b1, 1'b0);
      m_u.fr(1'b0);
      pst = 1'b1;
      repeat (24) @(negedge ref_clk);
      chk("power good early", 8'h00, {7'h00, pg});
      repeat (12) @(negedge ref_clk);
      chk("power good", 8'h01, {7'h00, pg});
      pst = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("power good off", 8'h00, {7'h00, pg});
      key_n = 1'b0;
      pv = 0;
      for (int k = 0; k < 6; k++)
      begin
         repeat ((tk[k] - pv) * 4) @(negedge ref_clk);
         pv = tk[k];
         chk("key", kx[k], {sp_n[2:0], lp_n[2:0], 1'b0, sd});
      end
      $display("test key timing done");
      end_sim();
   end
endmodule
